// ### src/rx_timing_defines.svh
`ifndef RX_TIMING_DEFINES_SVH
`define RX_TIMING_DEFINES_SVH

`define ADDR_BIT_CHECK_MIN_LIMIT 4'h4
`define ADDR_BAUD_RANGE_MAX_LIMIT 4'h5
`define ADDR_STATUS 4'h8

// bit check code 01, min limit 16
`define CFG5_RESET 8'h50
// rate range two, max limit 28
`define CFG6_RESET 8'h9C

`define BIT_CHECK_CODE_0 2'h0
`define BIT_CHECK_CODE_1 2'h1
`define BIT_CHECK_CODE_2 2'h2
`define BITS_CODE_0 4'h0
`define BITS_CODE_1 4'h3
`define BITS_CODE_2 4'h6
`define BITS_CODE_3 4'h9

`define RANGE_BASE_DCLK 5'h08
`define LIMIT_EXT_FACTOR 5'h02
`define MAX_LIMIT_OFFSET 7'h01
`define TX_LIMIT_OFFSET 7'h01

`define SYNC_PIN_LOW 0
`define SYNC_PIN_PWR 1
`define SYNC_PIN_AUX 2

`endif

// ### src/rx_timing_pkg.sv
package rx_timing_pkg;

    typedef struct packed {
        logic [1:0] bit_check_count_sel;
        logic [5:0] lim_min;
    } bit_check_min_cfg_t;

    typedef struct packed {
        logic [1:0] rate_range;
        logic [5:0] lim_max;
    } baud_range_max_cfg_t;

    typedef struct packed {
        logic p_on_aux;
        logic low_batt;
        logic power_on;
        logic [4:0] key_input_event_flag;
    } status_t;

    typedef struct packed {
        logic [3:0] bit_check_bits;
        logic [4:0] xdclk_in_dclk;
        logic [10:0] min_interval_dclk;
        logic [10:0] max_interval_dclk;
        logic [10:0] tx_half_bit_dclk;
    } timing_t;

endpackage

// ### src/rx_bitcheck_timing_status_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "rx_timing_defines.svh"

module rx_bitcheck_timing_status_regs
    import rx_timing_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic limit_extension_bit,
    input wire logic dclk_tick,
    input wire logic [4:0] key_event,
    input wire logic [4:0] key_state,
    input wire logic pwr_on_pin,
    input wire logic vsout_low_pin,
    input wire logic vaux_ok_pin,
    output logic irq,
    output timing_t timing,
    output logic xdclk_tick
);

    bit_check_min_cfg_t cfg5, next_cfg5;
    baud_range_max_cfg_t cfg6, next_cfg6;
    status_t status, next_status;
    logic next_irq;
    logic [7:0] next_rdata;
    timing_t next_timing;
    logic [2:0] sync1, sync2, sync3, pin_level, next_pin_level, pin_rise;
    logic [4:0] xdclk_cnt, next_xdclk_cnt;
    logic next_xdclk_tick;
    logic status_rd, set_evt;

    // product of a limit and the xdclk length, widest case 127 x 16 (lim_max of 0 wraps to 127)
    function automatic logic [10:0] scale(input logic [6:0] lim, input logic [4:0] mult);
        logic [11:0] prod;
        prod = 12'(lim) * 12'(mult);
        return prod[10:0];
    endfunction

    // configuration registers
    always_comb begin
        next_cfg5 = cfg5;
        next_cfg6 = cfg6;
        if (wr_en && addr == `ADDR_BIT_CHECK_MIN_LIMIT) begin
            next_cfg5 = wdata;
        end
        if (wr_en && addr == `ADDR_BAUD_RANGE_MAX_LIMIT) begin
            next_cfg6 = wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg5 <= `CFG5_RESET;
            cfg6 <= `CFG6_RESET;
        end else begin
            cfg5 <= next_cfg5;
            cfg6 <= next_cfg6;
        end
    end

    // derived timing; values below the supported floor are passed through unchecked
    always_comb begin
        next_timing = '0;
        unique case (cfg5.bit_check_count_sel)
            `BIT_CHECK_CODE_0: next_timing.bit_check_bits = `BITS_CODE_0;
            `BIT_CHECK_CODE_1: next_timing.bit_check_bits = `BITS_CODE_1;
            `BIT_CHECK_CODE_2: next_timing.bit_check_bits = `BITS_CODE_2;
            default: next_timing.bit_check_bits = `BITS_CODE_3;
        endcase
        next_timing.xdclk_in_dclk = `RANGE_BASE_DCLK >> cfg6.rate_range;
        if (limit_extension_bit) begin
            next_timing.xdclk_in_dclk = 5'(next_timing.xdclk_in_dclk * `LIMIT_EXT_FACTOR);
        end
        next_timing.min_interval_dclk = scale({1'b0, cfg5.lim_min}, next_timing.xdclk_in_dclk);
        next_timing.max_interval_dclk =
            scale(7'({1'b0, cfg6.lim_max} - `MAX_LIMIT_OFFSET), next_timing.xdclk_in_dclk);
        next_timing.tx_half_bit_dclk =
            scale(7'({1'b0, cfg5.lim_min} + `TX_LIMIT_OFFSET), next_timing.xdclk_in_dclk);
    end

    // xdclk tick from decoder clock ticks
    always_comb begin
        next_xdclk_cnt = xdclk_cnt;
        next_xdclk_tick = 1'b0;
        if (dclk_tick) begin
            if (xdclk_cnt + 5'h01 >= timing.xdclk_in_dclk) begin
                next_xdclk_cnt = '0;
                next_xdclk_tick = 1'b1;
            end else begin
                next_xdclk_cnt = xdclk_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timing <= '0;
            xdclk_cnt <= '0;
            xdclk_tick <= 1'b0;
        end else begin
            timing <= next_timing;
            xdclk_cnt <= next_xdclk_cnt;
            xdclk_tick <= next_xdclk_tick;
        end
    end

    // pin synchronisers; a level counts once the last two stages agree
    always_comb begin
        next_pin_level = pin_level;
        for (int i = 0; i < 3; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pin_level[i] = sync3[i];
            end
        end
        pin_rise = next_pin_level & ~pin_level;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_level <= '0;
        end else begin
            sync1 <= {vaux_ok_pin, pwr_on_pin, vsout_low_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            pin_level <= next_pin_level;
        end
    end

    // status flags and interrupt; a new event beats a same-cycle read, except the read clears irq when the rising pin's flag was already set
    always_comb begin
        status_rd = rd_en && addr == `ADDR_STATUS;
        set_evt = (pin_rise[`SYNC_PIN_PWR] && !status.power_on) ||
                  (pin_rise[`SYNC_PIN_AUX] && !status.p_on_aux) || (|key_event);
        next_status = status;
        next_status.key_input_event_flag = key_state;
        if (status_rd) begin
            next_status.power_on = 1'b0;
            next_status.low_batt = 1'b0;
            next_status.p_on_aux = 1'b0;
        end
        if (pin_rise[`SYNC_PIN_PWR]) begin
            next_status.power_on = 1'b1;
        end
        if (pin_level[`SYNC_PIN_LOW]) begin
            next_status.low_batt = 1'b1;
        end
        if (pin_rise[`SYNC_PIN_AUX]) begin
            next_status.p_on_aux = 1'b1;
        end
        next_irq = irq;
        if (status_rd) begin
            next_irq = 1'b0;
        end
        if (set_evt) begin
            next_irq = 1'b1;
        end
        next_rdata = rdata;
        if (rd_en) begin
            unique case (addr)
                `ADDR_BIT_CHECK_MIN_LIMIT: next_rdata = cfg5;
                `ADDR_BAUD_RANGE_MAX_LIMIT: next_rdata = cfg6;
                `ADDR_STATUS: next_rdata = status;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
            irq <= 1'b0;
            rdata <= 8'h00;
        end else begin
            status <= next_status;
            irq <= next_irq;
            rdata <= next_rdata;
        end
    end

    sequence cfg5_written;
        wr_en && addr == `ADDR_BIT_CHECK_MIN_LIMIT;
    endsequence

    sequence timing_settled;
        ##2 1'b1;
    endsequence

    chk_cfg_write_lands: assert property (@(posedge clk) disable iff (!nrst)
        cfg5_written |=> cfg5 == $past(wdata)) else $error("control register write lost");

    chk_bitcheck_decode: assert property (@(posedge clk) disable iff (!nrst)
        cfg5_written ##0 wdata[7:6] == `BIT_CHECK_CODE_2 ##1 !wr_en |-> ##1 timing.bit_check_bits == `BITS_CODE_2)
        else $error("bit check count wrong");

    chk_xdclk_length: assert property (@(posedge clk) disable iff (!nrst)
        $stable(cfg6) && $stable(limit_extension_bit) |=> timing.xdclk_in_dclk ==
            (5'((`RANGE_BASE_DCLK >> $past(cfg6.rate_range)) << $past(limit_extension_bit))))
        else $error("xdclk length wrong");

    chk_min_interval: assert property (@(posedge clk) disable iff (!nrst)
        $stable(cfg5) && $stable(cfg6) && $stable(limit_extension_bit) ##1 $stable(cfg5)
        |-> timing.min_interval_dclk == 11'($past(cfg5.lim_min) * timing.xdclk_in_dclk))
        else $error("min interval wrong");

    chk_tx_half_bit: assert property (@(posedge clk) disable iff (!nrst)
        timing.tx_half_bit_dclk >= timing.min_interval_dclk &&
        timing.tx_half_bit_dclk - timing.min_interval_dclk == 11'(timing.xdclk_in_dclk))
        else $error("tx half bit wrong");

    chk_max_interval: assert property (@(posedge clk) disable iff (!nrst)
        $stable(cfg6) && $stable(limit_extension_bit) ##1 $stable(cfg6) |->
        timing.max_interval_dclk + 11'(timing.xdclk_in_dclk) == 11'(cfg6.lim_max * timing.xdclk_in_dclk))
        else $error("max interval wrong");

    chk_power_wake_irq: assert property (@(posedge clk) disable iff (!nrst)
        pin_rise[`SYNC_PIN_PWR] && !status.power_on |=> status.power_on && irq)
        else $error("wake flag or interrupt missing");

    chk_read_clears: assert property (@(posedge clk) disable iff (!nrst)
        status_rd && !set_evt && !pin_rise[`SYNC_PIN_PWR] |=> !irq && !status.power_on)
        else $error("status read did not clear");

    chk_key_irq: assert property (@(posedge clk) disable iff (!nrst)
        |key_event |=> irq) else $error("key event without interrupt");

    chk_status_readback: assert property (@(posedge clk) disable iff (!nrst)
        status_rd |=> rdata == $past(status)) else $error("status read data wrong");

    chk_timing_follows: assert property (@(posedge clk) disable iff (!nrst)
        cfg5_written ##0 wdata[7:6] == `BIT_CHECK_CODE_0 ##1 !wr_en |-> timing_settled
        ##0 timing.bit_check_bits == `BITS_CODE_0) else $error("timing not updated");

endmodule

`default_nettype wire

// ### dv/mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
    input wire logic clk,
    output logic wr_en,
    output logic rd_en,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
    end
    // fsk-only controller, so every baud range code is legal here
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    // rdata registered, settled by the next falling edge
    task automatic read(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rx_timing_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en, rd_en, irq, xdclk_tick;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic ext = 1'b0;
    logic dclk_tick = 1'b0;
    logic [1:0] dc = 2'h0;
    logic [4:0] key_event = 5'h00;
    logic [4:0] key_state = 5'h15;
    logic pwr = 1'b0, vlow = 1'b0, vaux = 1'b0;
    timing_t timing;
    int n_fail = 0, checked = 0;
    always #12.5 clk = ~clk;
    always @(negedge clk) begin
        dc <= dc + 2'h1;
        dclk_tick <= (dc == 2'h0);
    end
    mcu_model u_mcu (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
    rx_bitcheck_timing_status_regs dut (.clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .limit_extension_bit(ext), .dclk_tick(dclk_tick), .key_event(key_event),
        .key_state(key_state), .pwr_on_pin(pwr), .vsout_low_pin(vlow), .vaux_ok_pin(vaux), .irq(irq),
        .timing(timing), .xdclk_tick(xdclk_tick));
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        u_mcu.read(a, d);
        check(what, {3'h0, exp}, {3'h0, d});
    endtask
    task automatic expect_timing(input logic [7:0] c5, input logic [7:0] c6, input logic e);
        int xd, m, x;
        xd = (8 >> c6[7:6]) * (e ? 2 : 1);
        m = int'(c5[5:0]);
        x = int'(c6[5:0]);
        check("bits", 11'(int'(c5[7:6]) * 3), {7'h0, timing.bit_check_bits});
        check("xdclk", 11'(xd), {6'h0, timing.xdclk_in_dclk});
        check("min", 11'(m * xd), timing.min_interval_dclk);
        check("max", 11'((x - 1) * xd), timing.max_interval_dclk);
        check("tx", 11'((m + 1) * xd), timing.tx_half_bit_dclk);
    endtask
    task automatic t_reset();
        rd(4'h4, 8'h50, "cfg5_rst");
        rd(4'h5, 8'h9C, "cfg6_rst");
        expect_timing(8'h50, 8'h9C, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_timing();
        int n;
        for (int i = 0; i < 4; i++) begin
            u_mcu.write(4'h4, {2'(i), 6'(10 + i * 17)});
            u_mcu.write(4'h5, {2'(i), 6'(12 + i * 17)});
            ext = i[0];
            repeat (3) @(negedge clk);
            rd(4'h4, {2'(i), 6'(10 + i * 17)}, "cfg5");
            expect_timing({2'(i), 6'(10 + i * 17)}, {2'(i), 6'(12 + i * 17)}, i[0]);
        end
        n = 0;
        repeat (80) begin
            @(negedge clk);
            n += int'(xdclk_tick);
        end
        // 20 decoder ticks at two per extended period, phase unknown
        check("xdclk_ticks", 11'h1, {10'h0, n >= 9 && n <= 11});
        $display("test timing done");
    endtask
    task automatic t_unmapped();
        rd(4'h3, 8'h00, "unmapped");
        u_mcu.write(4'h6, 8'h00);
        rd(4'h4, 8'hFD, "cfg5_kept");
        rd(4'h5, 8'hFF, "cfg6_kept");
        $display("test unmapped done");
    endtask
    task automatic t_status();
        pwr = 1'b1;
        repeat (8) @(negedge clk);
        check("irq_pwr", 11'h1, {10'h0, irq});
        rd(4'h8, 8'h35, "st_pwr");
        check("irq_clr", 11'h0, {10'h0, irq});
        rd(4'h8, 8'h15, "st_pwr_clr");
        vaux = 1'b1;
        repeat (8) @(negedge clk);
        check("irq_aux", 11'h1, {10'h0, irq});
        rd(4'h8, 8'h95, "st_aux");
        rd(4'h8, 8'h15, "st_aux_clr");
        vlow = 1'b1;
        repeat (8) @(negedge clk);
        check("irq_low", 11'h0, {10'h0, irq});
        rd(4'h8, 8'h55, "st_low");
        vlow = 1'b0;
        repeat (8) @(negedge clk);
        rd(4'h8, 8'h55, "st_low_held");
        rd(4'h8, 8'h15, "st_low_clr");
        key_event = 5'h04;
        @(negedge clk);
        key_event = 5'h00;
        repeat (2) @(negedge clk);
        check("irq_key", 11'h1, {10'h0, irq});
        rd(4'h8, 8'h15, "st_key");
        check("irq_key_clr", 11'h0, {10'h0, irq});
        // key levels show in the low status bits without raising the interrupt
        key_state = 5'h0A;
        rd(4'h8, 8'h0A, "st_key_levels");
        check("irq_key_level", 11'h0, {10'h0, irq});
        $display("test status done");
    endtask
    task automatic conclude();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial begin
        #(25 * 4000);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_reset();
        t_timing();
        t_unmapped();
        t_status();
        conclude();
    end
endmodule
`default_nettype wire
